// ---- design/psr_pkg.sv ----
// Package: constants and carrier types for the parallel-in serial-out shift register
`default_nettype none
package psr_pkg;
  // ----------------------------------------
  // Sizes and reset values
  // ----------------------------------------
  localparam int          STAGES      = 8;
  localparam int          SYNC_DEPTH  = 3;
  localparam logic [7:0]  STAGE_RESET = 8'h00;
  localparam logic [2:0]  SYNC_RESET  = 3'h0;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  // Control pins sampled together
  typedef struct packed {
    logic shift_not_load;
    logic clock_in;
    logic clock_inhibit;
    logic serial_in;
  } psr_ctrl_s;

  // Serial output pair
  typedef struct packed {
    logic serial_out;
    logic serial_out_n;
  } psr_out_s;

  // Action chosen for one system clock
  typedef enum logic [1:0] {
    PSR_HOLD,
    PSR_LOAD,
    PSR_SHIFT
  } psr_act_e;
endpackage
`default_nettype wire

// ---- design/psr_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`default_nettype none
module psr_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             sys_clk,  // System clock
  input  wire logic             reset_n,  // Synchronous reset, active low
  input  wire logic [WIDTH-1:0] pin,      // Raw asynchronous pins
  output logic      [WIDTH-1:0] level     // Filtered level
);
  // ----------------------------------------
  // Sync chains
  // ----------------------------------------
  logic [WIDTH-1:0] s1, s2, s3;
  logic [WIDTH-1:0] next_s1, next_s2, next_s3, next_level;

  // Refuse an empty pin group at elaboration
  if (WIDTH < 1) begin : g_width_check
    $error("WIDTH must be positive");
  end

  // Level changes only once stages two and three agree; s1 feeds s2 alone
  always_comb begin
    next_s1    = pin;
    next_s2    = s1;
    next_s3    = s2;
    next_level = level;
    for (int i = 0; i < WIDTH; i++) begin
      if (s2[i] == s3[i]) begin
        next_level[i] = s3[i];
      end
    end
    if (!reset_n) begin
      next_s1    = '0;
      next_s2    = '0;
      next_s3    = '0;
      next_level = '0;
    end
  end

  // Register stage
  always_ff @(posedge sys_clk) begin
    s1    <= next_s1;
    s2    <= next_s2;
    s3    <= next_s3;
    level <= next_level;
  end
endmodule
`default_nettype wire

// ---- design/psr_top.sv ----
// Eight-stage parallel-in serial-out shift register, device side
`default_nettype none
module psr_top #(
  parameter int STAGES = psr_pkg::STAGES
) (
  input  wire logic              sys_clk,         // System clock, 250 MHz
  input  wire logic              reset_n,         // Synchronous reset, active low
  input  wire logic              shift_not_load,  // High shifts, low loads
  input  wire logic              clock_in,        // Shift clock pin
  input  wire logic              clock_inhibit,   // Gating clock pin
  input  wire logic              serial_in,       // Serial fill data
  input  wire logic [STAGES-1:0] par_data,        // Direct parallel data, bit 0 = first stage
  output logic                   serial_out,      // Last stage
  output logic                   serial_out_n     // Complement of last stage
);
  // ----------------------------------------
  // Checks and declarations
  // ----------------------------------------
  // Refuse a chain too short to shift through
  if (STAGES < 2) begin : g_stages_check
    $error("STAGES must be at least 2");
  end

  psr_pkg::psr_ctrl_s ctrl_raw, ctrl;
  logic [STAGES-1:0]  par_sync;
  logic [STAGES-1:0]  stage, next_stage;
  logic               clk_prev, inh_prev, next_clk_prev, next_inh_prev;
  logic               clk_rise, inh_rise;
  psr_pkg::psr_act_e  act;
  psr_pkg::psr_out_s  out_pair;

  assign ctrl_raw = '{shift_not_load: shift_not_load, clock_in: clock_in,
                      clock_inhibit: clock_inhibit, serial_in: serial_in};

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Load data is asynchronous too, so it gets the same filter; a load thus lags the pins by a few cycles
  psr_sync #(
    .WIDTH ($bits(psr_pkg::psr_ctrl_s))
  ) u_ctrl_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .pin     (ctrl_raw),
    .level   (ctrl)
  );

  psr_sync #(
    .WIDTH (STAGES)
  ) u_data_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .pin     (par_data),
    .level   (par_sync)
  );

  // ----------------------------------------
  // Edge detection and action
  // ----------------------------------------
  // The clock pins are symmetric: either rises while the other is low
  always_comb begin
    clk_rise = ctrl.clock_in && !clk_prev;
    inh_rise = ctrl.clock_inhibit && !inh_prev;
    if (!ctrl.shift_not_load) begin
      act = psr_pkg::PSR_LOAD;
    end else if ((clk_rise && !ctrl.clock_inhibit) ||
                 (inh_rise && !ctrl.clock_in)) begin
      act = psr_pkg::PSR_SHIFT;
    end else begin
      act = psr_pkg::PSR_HOLD;
    end
  end

  // ----------------------------------------
  // Stage register
  // ----------------------------------------
  // Next value of the stages and edge history
  always_comb begin
    // Loading, and synchroniser fill after reset, count as high so a pin already high never shifts
    next_clk_prev = ctrl.clock_in || !ctrl.shift_not_load;
    next_inh_prev = ctrl.clock_inhibit || !ctrl.shift_not_load;
    next_stage    = stage;
    case (act)
      psr_pkg::PSR_LOAD:  next_stage = par_sync;
      psr_pkg::PSR_SHIFT: next_stage = {stage[STAGES-2:0], ctrl.serial_in};
      psr_pkg::PSR_HOLD:  next_stage = stage;
      default:            next_stage = stage;
    endcase
    if (!reset_n) begin
      next_stage    = STAGES'(psr_pkg::STAGE_RESET);
      next_clk_prev = 1'b1;
      next_inh_prev = 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    stage    <= next_stage;
    clk_prev <= next_clk_prev;
    inh_prev <= next_inh_prev;
  end

  // Outputs come straight from the last flip-flop
  assign out_pair     = '{serial_out: stage[STAGES-1], serial_out_n: ~stage[STAGES-1]};
  assign serial_out   = out_pair.serial_out;
  assign serial_out_n = out_pair.serial_out_n;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sequence seq_shift_req;
    ctrl.shift_not_load && ((clk_rise && !ctrl.clock_inhibit) || (inh_rise && !ctrl.clock_in));
  endsequence

  AST_COMPLEMENT: assert property (@(posedge sys_clk) disable iff (!reset_n)
    serial_out_n == !serial_out) else $error("serial outputs not complementary");

  AST_SHIFT_CLK: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ctrl.shift_not_load && clk_rise && !ctrl.clock_inhibit |=> stage[0] == $past(ctrl.serial_in))
    else $error("clock edge did not shift serial_in in");

  AST_SHIFT_INH: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ctrl.shift_not_load && inh_rise && !ctrl.clock_in |=> stage[STAGES-1] == $past(stage[STAGES-2]))
    else $error("inhibit edge did not shift");

  AST_MOVE: assert property (@(posedge sys_clk) disable iff (!reset_n)
    seq_shift_req |=> stage[STAGES-1:1] == $past(stage[STAGES-2:0]))
    else $error("stages did not advance by one");

  AST_FIRST: assert property (@(posedge sys_clk) disable iff (!reset_n)
    seq_shift_req |=> stage[0] == $past(ctrl.serial_in))
    else $error("serial_in not captured by first stage");

  AST_LOAD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    !ctrl.shift_not_load |=> stage == $past(par_sync)) else $error("load did not follow data");

  AST_NOLOAD: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ctrl.shift_not_load && $changed(par_sync) &&
    !((clk_rise && !ctrl.clock_inhibit) || (inh_rise && !ctrl.clock_in)) |=> $stable(stage))
    else $error("parallel data leaked while shifting");

  AST_HOLD_HIGH: assert property (@(posedge sys_clk) disable iff (!reset_n)
    ctrl.shift_not_load && clk_prev && inh_prev && ctrl.clock_in && ctrl.clock_inhibit |=> $stable(stage))
    else $error("stages changed with both clocks high");

  AST_LOAD_PIN: assert property (@(posedge sys_clk) disable iff (!reset_n)
    (!ctrl.shift_not_load)[*2] |-> stage == $past(par_sync)) else $error("stage missed its data input");
endmodule
`default_nettype wire

// ---- dv/psr_host.sv ----
// Host controller model that sequences the shift register pins
`default_nettype none
module psr_host (
  input  wire logic       sys_clk,         // System clock
  output var  logic       shift_not_load,  // Low loads
  output var  logic       clock_in,        // Shift clock
  output var  logic       clock_inhibit,   // Gating clock
  output var  logic       serial_in,       // Serial fill
  output var  logic [7:0] par_data         // Parallel data
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle in shift mode with both clocks low
  initial begin
    {shift_not_load, clock_in, clock_inhibit, serial_in} = 4'h8;
    par_data = 8'h00;
  end
  // Pins change off the falling edge, then hold well past the sync latency
  task automatic step(input logic [3:0] pins, input logic [7:0] d);
    @(negedge sys_clk);
    {shift_not_load, clock_in, clock_inhibit, serial_in} = pins;
    par_data = d;
    repeat (8) @(negedge sys_clk);
  endtask
  // Inhibit is raised only once the clock is high, so the inhibit edge never shifts
  task automatic gate();
    step(4'hC, par_data);
    step(4'hE, par_data);
  endtask
endmodule
`default_nettype wire

// ---- dv/piso_shift_register_8bit_tb.sv ----
// Self-checking testbench for the shift register
`default_nettype none
module piso_shift_register_8bit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] LD = 8'h5A;
  logic       sys_clk;
  logic       reset_n;
  logic       shift_not_load;
  logic       clock_in;
  logic       clock_inhibit;
  logic       serial_in;
  logic [7:0] par_data;
  logic       serial_out;
  logic       serial_out_n;
  int         n_fail = 0;
  int         n_compared = 0;

  psr_host psr_host_inst (.sys_clk(sys_clk), .shift_not_load(shift_not_load), .clock_in(clock_in),
    .clock_inhibit(clock_inhibit), .serial_in(serial_in), .par_data(par_data));
  psr_top psr_top_inst (.sys_clk(sys_clk), .reset_n(reset_n), .shift_not_load(shift_not_load),
    .clock_in(clock_in), .clock_inhibit(clock_inhibit), .serial_in(serial_in),
    .par_data(par_data), .serial_out(serial_out), .serial_out_n(serial_out_n));

  // ----------------------------------------
  // Clock, checks and closing
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // The output pair is always compared together, so a stuck inverter shows
  task automatic check(input logic [1:0] seen, input logic [1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic out_is(input logic b);
    check({serial_out, serial_out_n}, {b, ~b});
  endtask
  task automatic wrap_up();
    $display("Compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Load overrides both clocks held high, then follows new data
  task automatic t_load();
    psr_host_inst.step(4'h6, 8'hA5);
    out_is(1'b1);
    psr_host_inst.step(4'h0, LD);
    out_is(1'b0);
    psr_host_inst.step(4'h8, LD);
  endtask
  // Eight clock shifts with changing parallel data and a serial fill
  task automatic t_shift();
    for (int i = 0; i < 8; i++) begin
      psr_host_inst.step({3'h4, ~i[0]}, 8'hFF);
      psr_host_inst.step({3'h6, ~i[0]}, 8'hFF);
      out_is((i < 7) ? LD[6-i] : 1'b1);
    end
  endtask
  // Contents now 8'hAA: edges while the other clock is high do nothing
  task automatic t_hold();
    psr_host_inst.gate();
    out_is(1'b1);
    psr_host_inst.step(4'hA, 8'h00);
    psr_host_inst.step(4'hE, 8'h00);
    out_is(1'b1);
  endtask
  // Inhibit acts as the clock while clock_in is low
  task automatic t_inh();
    for (int i = 0; i < 2; i++) begin
      psr_host_inst.step(4'h8, 8'h00);
      psr_host_inst.step(4'hA, 8'h00);
      out_is(i[0]);
    end
  endtask

  // Watchdog: the run needs about 260 cycles
  initial begin
    #20000;
    n_fail++;
    wrap_up();
  end
  initial begin
    reset_n = 1'b0;
    repeat (5) @(negedge sys_clk);
    out_is(1'b0);
    reset_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    t_load();
    t_shift();
    t_hold();
    t_inh();
    wrap_up();
  end
endmodule
`default_nettype wire
